// >>> rtl/usb_dl_pkg.sv
// Constants, field positions and types shared by the code download bridge.
package usb_dl_pkg;
  // Vendor request encodings seen on the default control endpoint.
  localparam logic [7:0] REQTYPE_VENDOR_OUT = 8'h40;
  localparam logic [7:0] REQTYPE_VENDOR_IN = 8'hc0;
  localparam logic [7:0] REQ_REGISTER_ACCESS = 8'ha0;
  localparam logic [7:0] REQ_MCU_CODE_LOAD = 8'ha1;
  localparam logic [15:0] REG_XFER_LEN = 16'h0002;
  localparam logic [15:0] SETUP_INDEX_ZERO = 16'h0000;
  // Decoded setup request kinds.
  localparam logic [2:0] KIND_NONE = 3'h0;
  localparam logic [2:0] KIND_MCU_CODE = 3'h1;
  localparam logic [2:0] KIND_REG_WRITE = 3'h2;
  localparam logic [2:0] KIND_REG_READ = 3'h3;
  localparam logic [2:0] KIND_OTHER = 3'h4;
  // APB byte offsets.
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_IO_ADDR = 12'h004;
  localparam logic [11:0] OFF_IO_DATA = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00c;
  localparam logic [11:0] OFF_DL_BASE = 12'h010;
  localparam logic [11:0] OFF_DL_WPTR = 12'h020;
  localparam logic [11:0] OFF_EP_DESC = 12'h040;
  localparam logic [11:0] OFF_BUF_BASE = 12'h060;
  localparam logic [11:0] OFF_BUF_SIZE = 12'h080;
  localparam logic [11:0] OFF_BUF_RD = 12'h0a0;
  localparam logic [11:0] OFF_BUF_WR = 12'h0c0;
  // Field positions.
  localparam int CTRL_FW_LOADED_BIT = 0;
  localparam int IO_START_BIT = 15;
  localparam int IO_WRITE_BIT = 14;
  localparam int REG_SPACE_MCU_BIT = 15;
  localparam int DESC_DIR_IN_BIT = 2;
  localparam int DESC_MAXPKT_LSB = 4;
  // Widths and reset values.
  localparam int PM_ADDR_W = 18;
  localparam int MAXPKT_W = 10;
  localparam logic [17:0] WPTR_RESET = 18'h3_ffff;
  localparam logic [17:0] WPTR_STEP = 18'h0_0001;
  // Fixed endpoint definitions.
  localparam logic [1:0] XFER_CONTROL = 2'h0;
  localparam logic [1:0] XFER_BULK = 2'h2;
  localparam logic [9:0] CTRL_EP_MAXPKT = 10'h008;
  localparam logic [9:0] CODE_EP_MAXPKT = 10'h040;
  localparam int CODE_EPS = 3;
  localparam int PROG_EPS = 8;
  localparam logic [3:0] FIRST_PROG_EP = 4'h4;
  localparam logic [3:0] LAST_PROG_EP = 4'hb;
  typedef enum logic [0:0] {BR_IDLE = 1'b0, BR_BUSY = 1'b1} bridge_state_e;
endpackage : usb_dl_pkg

// >>> rtl/code_word_packer.sv
// Gathers four download bytes into one 24-bit instruction and tracks the write offset.
`timescale 1ns/1ps
module code_word_packer (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic byte_valid_i,
  input wire logic [7:0] byte_i,
  input wire logic base_load_i,
  output logic word_valid_o,
  output logic [23:0] word_o,
  output logic [17:0] wptr_o
);
  logic [1:0] count;
  logic [15:0] low_bytes;

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      count <= 2'h0;
    end else if (base_load_i) begin
      count <= 2'h0;
    end else if (byte_valid_i) begin
      count <= count + 2'h1;
    end
  end

  // The first byte of each group is the zero pad and is never kept.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      low_bytes <= 16'h0000;
    end else if (byte_valid_i && count == 2'h1) begin
      low_bytes[7:0] <= byte_i;
    end else if (byte_valid_i && count == 2'h2) begin
      low_bytes[15:8] <= byte_i;
    end
  end

  assign word_valid_o = byte_valid_i && count == 2'h3 && !base_load_i;
  assign word_o = {byte_i, low_bytes};

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      wptr_o <= usb_dl_pkg::WPTR_RESET;
    end else if (base_load_i) begin
      wptr_o <= usb_dl_pkg::WPTR_RESET;
    end else if (word_valid_o) begin
      wptr_o <= wptr_o + usb_dl_pkg::WPTR_STEP;
    end
  end
endmodule : code_word_packer

// >>> rtl/usb_code_download_bridge.sv
// Vendor request decode, register bridge and DSP code download path of the USB block.
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/1ps
module usb_code_download_bridge #(
  parameter int IO_ADDR_W = 14
) (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic setup_valid_i,
  input wire logic [63:0] setup_pkt_i,
  output logic [2:0] setup_kind_o,
  output logic [15:0] setup_addr_o,
  output logic [15:0] setup_len_o,
  output logic reg_space_mcu_o,
  input wire logic bulk_valid_i,
  input wire logic [1:0] bulk_ep_i,
  input wire logic [7:0] bulk_data_i,
  output logic bulk_ready_o,
  output logic pm_we_o,
  output logic [17:0] pm_addr_o,
  output logic [23:0] pm_data_o,
  output logic dsp_req_o,
  output logic dsp_we_o,
  output logic [13:0] dsp_addr_o,
  output logic [15:0] dsp_wdata_o,
  input wire logic dsp_ack_i,
  input wire logic [15:0] dsp_rdata_i,
  input wire logic [3:0] ep_sel_i,
  output logic [1:0] ep_type_o,
  output logic ep_dir_in_o,
  output logic [9:0] ep_maxpkt_o,
  output logic [17:0] ep_buf_base_o,
  output logic [15:0] ep_buf_size_o
);
  logic fw_loaded;
  logic [15:0] io_addr;
  logic [15:0] io_data;
  usb_dl_pkg::bridge_state_e state;
  logic [17:0] dl_base [usb_dl_pkg::CODE_EPS];
  logic [17:0] wptr [usb_dl_pkg::CODE_EPS];
  logic [15:0] ep_desc [usb_dl_pkg::PROG_EPS];
  logic [17:0] buf_base [usb_dl_pkg::PROG_EPS];
  logic [15:0] buf_size [usb_dl_pkg::PROG_EPS];
  logic [15:0] buf_rd [usb_dl_pkg::PROG_EPS];
  logic [15:0] buf_wr [usb_dl_pkg::PROG_EPS];
  logic [usb_dl_pkg::CODE_EPS-1:0] base_load;
  logic [usb_dl_pkg::CODE_EPS-1:0] word_valid;
  logic [23:0] word [usb_dl_pkg::CODE_EPS];
  logic [1:0] pm_ep;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic apb_write;
  logic [2:0] gidx;
  logic [2:0] next_kind;

  // Writes land on the edge where the master sees pready; one wait state always.
  assign apb_write = psel_i && penable_i && pready_o && pwrite_i;
  assign gidx = paddr_i[4:2];

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= psel_i && penable_i && !pready_o;
      if (psel_i && penable_i && !pready_o) begin
        prdata_o <= pwrite_i ? 32'h0000_0000 : next_prdata;
        pslverr_o <= next_pslverr;
      end else begin
        pslverr_o <= 1'b0;
      end
    end
  end

  always_comb begin
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    unique casez (paddr_i)
      usb_dl_pkg::OFF_CTRL: next_prdata = {31'h0, fw_loaded};
      usb_dl_pkg::OFF_IO_ADDR: next_prdata = {16'h0000, io_addr};
      usb_dl_pkg::OFF_IO_DATA: next_prdata = {16'h0000, io_data};
      usb_dl_pkg::OFF_STATUS: next_prdata = {31'h0, state == usb_dl_pkg::BR_BUSY};
      12'h01?, 12'h02?: begin
        if (paddr_i[3:2] == 2'h3) begin
          next_pslverr = 1'b1;
        end else if (paddr_i[5]) begin
          next_prdata = {14'h0000, wptr[paddr_i[3:2]]};
        end else begin
          next_prdata = {14'h0000, dl_base[paddr_i[3:2]]};
        end
      end
      12'h04?, 12'h05?: next_prdata = {16'h0000, ep_desc[gidx]};
      12'h06?, 12'h07?: next_prdata = {14'h0000, buf_base[gidx]};
      12'h08?, 12'h09?: next_prdata = {16'h0000, buf_size[gidx]};
      12'h0a?, 12'h0b?: next_prdata = {16'h0000, buf_rd[gidx]};
      12'h0c?, 12'h0d?: next_prdata = {16'h0000, buf_wr[gidx]};
      default: next_pslverr = 1'b1;
    endcase
    if (paddr_i[1:0] != 2'h0) begin
      next_pslverr = 1'b1;
    end
  end

  // Software sets this only after re-enumeration under downloaded firmware.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      fw_loaded <= 1'b0;
    end else if (apb_write && paddr_i == usb_dl_pkg::OFF_CTRL) begin
      fw_loaded <= pwdata_i[usb_dl_pkg::CTRL_FW_LOADED_BIT];
    end
  end

  // Programmable endpoint pool, open to every interface.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < usb_dl_pkg::PROG_EPS; i++) begin
        ep_desc[i] <= 16'h0000;
        buf_base[i] <= 18'h0_0000;
        buf_size[i] <= 16'h0000;
        buf_rd[i] <= 16'h0000;
        buf_wr[i] <= 16'h0000;
      end
    end else if (apb_write && paddr_i[1:0] == 2'h0) begin
      unique casez (paddr_i[11:5])
        7'h02: ep_desc[gidx] <= pwdata_i[15:0];
        7'h03: buf_base[gidx] <= pwdata_i[17:0];
        7'h04: buf_size[gidx] <= pwdata_i[15:0];
        7'h05: buf_rd[gidx] <= pwdata_i[15:0];
        7'h06: buf_wr[gidx] <= pwdata_i[15:0];
        default: ;
      endcase
    end
  end

  // Each code endpoint keeps its own download address.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      for (int i = 0; i < usb_dl_pkg::CODE_EPS; i++) begin
        dl_base[i] <= 18'h0_0000;
      end
    end else begin
      for (int i = 0; i < usb_dl_pkg::CODE_EPS; i++) begin
        if (base_load[i]) begin
          dl_base[i] <= pwdata_i[17:0];
        end
      end
    end
  end

  for (genvar g = 0; g < usb_dl_pkg::CODE_EPS; g++) begin : g_code_ep
    assign base_load[g] = apb_write && paddr_i == usb_dl_pkg::OFF_DL_BASE + 12'(4 * g);
    code_word_packer u_packer (
      .clock_i(clock_i),
      .rst_i(rst_i),
      .byte_valid_i(bulk_valid_i && bulk_ready_o && bulk_ep_i == 2'(g + 1)),
      .byte_i(bulk_data_i),
      .base_load_i(base_load[g]),
      .word_valid_o(word_valid[g]),
      .word_o(word[g]),
      .wptr_o(wptr[g])
    );
  end

  // Ready only tracks the firmware flag, so transfers of any length flow.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      bulk_ready_o <= 1'b0;
    end else begin
      bulk_ready_o <= fw_loaded;
    end
  end

  // Only one byte arrives per cycle, so at most one packer completes at a time.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      pm_we_o <= 1'b0;
      pm_addr_o <= 18'h0_0000;
      pm_data_o <= 24'h00_0000;
      pm_ep <= 2'h0;
    end else begin
      pm_we_o <= |word_valid;
      for (int i = 0; i < usb_dl_pkg::CODE_EPS; i++) begin
        if (word_valid[i]) begin
          pm_addr_o <= dl_base[i] + wptr[i] + usb_dl_pkg::WPTR_STEP;
          pm_data_o <= word[i];
          pm_ep <= 2'(i);
        end
      end
    end
  end

  // Bridged DSP register access through the address and data pair.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      state <= usb_dl_pkg::BR_IDLE;
      io_addr <= 16'h0000;
      io_data <= 16'h0000;
    end else begin
      if (apb_write && paddr_i == usb_dl_pkg::OFF_IO_DATA && state == usb_dl_pkg::BR_IDLE) begin
        io_data <= pwdata_i[15:0];
      end
      unique case (state)
        usb_dl_pkg::BR_IDLE: begin
          if (apb_write && paddr_i == usb_dl_pkg::OFF_IO_ADDR) begin
            io_addr <= pwdata_i[15:0];
            if (pwdata_i[usb_dl_pkg::IO_START_BIT]) begin
              state <= usb_dl_pkg::BR_BUSY;
            end
          end
        end
        usb_dl_pkg::BR_BUSY: begin
          if (dsp_ack_i) begin
            io_addr[usb_dl_pkg::IO_START_BIT] <= 1'b0;
            if (!io_addr[usb_dl_pkg::IO_WRITE_BIT]) begin
              io_data <= dsp_rdata_i;
            end
            state <= usb_dl_pkg::BR_IDLE;
          end
        end
      endcase
    end
  end

  // Registers are frozen while an access is in flight, so the request stays stable.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      dsp_req_o <= 1'b0;
      dsp_we_o <= 1'b0;
      dsp_addr_o <= 14'h0000;
      dsp_wdata_o <= 16'h0000;
    end else begin
      dsp_req_o <= (state == usb_dl_pkg::BR_BUSY && !dsp_ack_i) ||
        (state == usb_dl_pkg::BR_IDLE && apb_write && paddr_i == usb_dl_pkg::OFF_IO_ADDR &&
         pwdata_i[usb_dl_pkg::IO_START_BIT]);
      if (state == usb_dl_pkg::BR_IDLE && apb_write && paddr_i == usb_dl_pkg::OFF_IO_ADDR) begin
        dsp_we_o <= pwdata_i[usb_dl_pkg::IO_WRITE_BIT];
        dsp_addr_o <= pwdata_i[IO_ADDR_W-1:0];
        dsp_wdata_o <= io_data;
      end
    end
  end

  // Setup packet decode; anything else vendor-shaped is left for a stall.
  always_comb begin
    next_kind = usb_dl_pkg::KIND_OTHER;
    if (setup_pkt_i[47:32] == usb_dl_pkg::SETUP_INDEX_ZERO) begin
      if (setup_pkt_i[7:0] == usb_dl_pkg::REQTYPE_VENDOR_OUT &&
          setup_pkt_i[15:8] == usb_dl_pkg::REQ_MCU_CODE_LOAD) begin
        next_kind = usb_dl_pkg::KIND_MCU_CODE;
      end else if (setup_pkt_i[15:8] == usb_dl_pkg::REQ_REGISTER_ACCESS &&
                   setup_pkt_i[63:48] == usb_dl_pkg::REG_XFER_LEN) begin
        if (setup_pkt_i[7:0] == usb_dl_pkg::REQTYPE_VENDOR_OUT) begin
          next_kind = usb_dl_pkg::KIND_REG_WRITE;
        end else if (setup_pkt_i[7:0] == usb_dl_pkg::REQTYPE_VENDOR_IN) begin
          next_kind = usb_dl_pkg::KIND_REG_READ;
        end
      end
    end
  end

  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      setup_kind_o <= usb_dl_pkg::KIND_NONE;
      setup_addr_o <= 16'h0000;
      setup_len_o <= 16'h0000;
      reg_space_mcu_o <= 1'b0;
    end else if (setup_valid_i) begin
      setup_kind_o <= next_kind;
      setup_addr_o <= setup_pkt_i[31:16];
      setup_len_o <= setup_pkt_i[63:48];
      reg_space_mcu_o <= setup_pkt_i[16 + usb_dl_pkg::REG_SPACE_MCU_BIT];
    end
  end

  // Endpoint definition lookup: fixed set first, then the pool.
  always_ff @(posedge clock_i or posedge rst_i) begin
    if (rst_i) begin
      ep_type_o <= usb_dl_pkg::XFER_CONTROL;
      ep_dir_in_o <= 1'b0;
      ep_maxpkt_o <= usb_dl_pkg::CTRL_EP_MAXPKT;
      ep_buf_base_o <= 18'h0_0000;
      ep_buf_size_o <= 16'h0000;
    end else if (ep_sel_i == 4'h0) begin
      ep_type_o <= usb_dl_pkg::XFER_CONTROL;
      ep_dir_in_o <= 1'b0;
      ep_maxpkt_o <= usb_dl_pkg::CTRL_EP_MAXPKT;
      ep_buf_base_o <= 18'h0_0000;
      ep_buf_size_o <= 16'h0000;
    end else if (ep_sel_i < usb_dl_pkg::FIRST_PROG_EP) begin
      ep_type_o <= usb_dl_pkg::XFER_BULK;
      ep_dir_in_o <= 1'b0;
      ep_maxpkt_o <= usb_dl_pkg::CODE_EP_MAXPKT;
      ep_buf_base_o <= dl_base[ep_sel_i[1:0] - 2'h1];
      ep_buf_size_o <= 16'h0000;
    end else if (ep_sel_i <= usb_dl_pkg::LAST_PROG_EP) begin
      ep_type_o <= ep_desc[3'(ep_sel_i - usb_dl_pkg::FIRST_PROG_EP)][1:0];
      ep_dir_in_o <= ep_desc[3'(ep_sel_i - usb_dl_pkg::FIRST_PROG_EP)][usb_dl_pkg::DESC_DIR_IN_BIT];
      ep_maxpkt_o <= ep_desc[3'(ep_sel_i - usb_dl_pkg::FIRST_PROG_EP)][13:4];
      ep_buf_base_o <= buf_base[3'(ep_sel_i - usb_dl_pkg::FIRST_PROG_EP)];
      ep_buf_size_o <= buf_size[3'(ep_sel_i - usb_dl_pkg::FIRST_PROG_EP)];
    end
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (rst_i);

  a_wptr_reload: assert property (base_load[0] |=> wptr[0] == usb_dl_pkg::WPTR_RESET)
    else $error("Write offset not reloaded after base write.");
  a_start_clear: assert property (state == usb_dl_pkg::BR_BUSY && dsp_ack_i |=> !io_addr[15] && !dsp_req_o)
    else $error("Start bit still set after access completed.");
  a_dsp_launch: assert property (state == usb_dl_pkg::BR_IDLE && apb_write && paddr_i == usb_dl_pkg::OFF_IO_ADDR
    && pwdata_i[15] |=> dsp_req_o && dsp_we_o == $past(pwdata_i[14]))
    else $error("Bridged access not launched with the right direction.");
  a_read_load: assert property (state == usb_dl_pkg::BR_BUSY && dsp_ack_i && !io_addr[14]
    |=> io_data == $past(dsp_rdata_i))
    else $error("Read result not placed in data register.");
  a_pm_address: assert property (pm_we_o |-> pm_addr_o == 18'(dl_base[pm_ep] + wptr[pm_ep]))
    else $error("Program write not at base plus offset.");
  a_code_decode: assert property (setup_valid_i && setup_pkt_i[15:0] == 16'ha140 && setup_pkt_i[47:32] == 16'h0000
    |=> setup_kind_o == usb_dl_pkg::KIND_MCU_CODE)
    else $error("Code load request not recognised.");
  a_regw_decode: assert property (setup_valid_i && setup_pkt_i[15:0] == 16'ha040 && setup_pkt_i[63:32] == 32'h0002_0000
    |=> setup_kind_o == usb_dl_pkg::KIND_REG_WRITE)
    else $error("Register write request not recognised.");
  a_regr_decode: assert property (setup_valid_i && setup_pkt_i[15:0] == 16'ha0c0 && setup_pkt_i[63:32] == 32'h0002_0000
    |=> setup_kind_o == usb_dl_pkg::KIND_REG_READ)
    else $error("Register read request not recognised.");
  a_bulk_gate: assert property (!fw_loaded |=> !bulk_ready_o)
    else $error("Bulk download open before firmware load.");
  a_fixed_eps: assert property (ep_sel_i inside {4'h1, 4'h2, 4'h3} |=> ep_maxpkt_o == 10'h040 && !ep_dir_in_o)
    else $error("Code endpoint definition wrong.");
  a_ctrl_ep: assert property (ep_sel_i == 4'h0 |=> ep_maxpkt_o == 10'h008)
    else $error("Control endpoint packet size wrong.");
  a_pack_strip: assert property (word_valid[0] |=> pm_we_o && pm_data_o[23:16] == $past(bulk_data_i))
    else $error("Instruction packing wrong.");

  c_dsp_read: cover property (state == usb_dl_pkg::BR_BUSY && dsp_ack_i && !io_addr[14]);
  c_pm_write: cover property (pm_we_o ##[1:8] pm_we_o);
  c_reg_write: cover property (setup_kind_o == usb_dl_pkg::KIND_REG_WRITE);
endmodule : usb_code_download_bridge

// >>> test/usb_host_model.sv
// Host-side model issuing vendor setup packets and bulk code bytes.
`timescale 1ns/1ps
module usb_host_model (
  input wire logic clock_i,
  input wire logic bulk_ready_i,
  output logic setup_valid_o,
  output logic [63:0] setup_pkt_o,
  output logic bulk_valid_o,
  output logic [1:0] bulk_ep_o,
  output logic [7:0] bulk_data_o
);
  initial begin
    setup_valid_o = 1'b0;
    setup_pkt_o = 64'h0000_0000_0000_0000;
    bulk_valid_o = 1'b0;
    bulk_ep_o = 2'h0;
    bulk_data_o = 8'h00;
  end
  // The packet is inverted once the pulse ends, so a late sample shows up as a wrong field.
  task automatic send_setup(input logic [7:0] rt, input logic [7:0] rq, input logic [15:0] val,
    input logic [15:0] idx, input logic [15:0] len);
    @(posedge clock_i);
    setup_valid_o <= 1'b1;
    setup_pkt_o <= {len, idx, val, rq, rt};
    @(posedge clock_i);
    setup_valid_o <= 1'b0;
    setup_pkt_o <= ~{len, idx, val, rq, rt};
  endtask : send_setup
  // Each byte is held until taken; the idle line shows the inverse of the last byte.
  task automatic send_instr(input logic [1:0] ep, input logic [23:0] ins);
    logic [31:0] grp;
    grp = {ins, 8'h00};
    @(posedge clock_i);
    for (int i = 0; i < 4; i++) begin
      bulk_valid_o <= 1'b1;
      bulk_ep_o <= ep;
      bulk_data_o <= grp[8*i +: 8];
      do @(posedge clock_i); while (bulk_ready_i !== 1'b1);
    end
    bulk_valid_o <= 1'b0;
    bulk_data_o <= ~grp[31:24];
  endtask : send_instr
endmodule : usb_host_model

// >>> test/usb_code_download_bridge_tb.sv
// Self-checking bench for the vendor request and code download bridge.
`timescale 1ns/1ps
module usb_code_download_bridge_tb;
  logic clock_i, rst_i, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic setup_valid, mcu, bulk_valid, bulk_ready, pm_we, dsp_req, dsp_we, dsp_ack, ep_dir;
  logic [63:0] setup_pkt;
  logic [2:0] kind;
  logic [15:0] saddr, slen, dsp_wdata, dsp_rdata, ep_size;
  logic [1:0] bulk_ep, ep_type;
  logic [7:0] bulk_data;
  logic [17:0] pm_addr, ep_base;
  logic [23:0] pm_data;
  logic [13:0] dsp_addr;
  logic [3:0] ep_sel;
  logic [9:0] ep_max;
  logic [17:0] pa[$];
  logic [23:0] pd[$];
  int n_mismatch, n_checks;
  usb_code_download_bridge i_dut (.clock_i(clock_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .setup_valid_i(setup_valid), .setup_pkt_i(setup_pkt), .setup_kind_o(kind),
    .setup_addr_o(saddr), .setup_len_o(slen), .reg_space_mcu_o(mcu), .bulk_valid_i(bulk_valid),
    .bulk_ep_i(bulk_ep), .bulk_data_i(bulk_data), .bulk_ready_o(bulk_ready), .pm_we_o(pm_we),
    .pm_addr_o(pm_addr), .pm_data_o(pm_data), .dsp_req_o(dsp_req), .dsp_we_o(dsp_we), .dsp_addr_o(dsp_addr),
    .dsp_wdata_o(dsp_wdata), .dsp_ack_i(dsp_ack), .dsp_rdata_i(dsp_rdata), .ep_sel_i(ep_sel),
    .ep_type_o(ep_type), .ep_dir_in_o(ep_dir), .ep_maxpkt_o(ep_max), .ep_buf_base_o(ep_base),
    .ep_buf_size_o(ep_size));
  usb_host_model i_host (.clock_i(clock_i), .bulk_ready_i(bulk_ready), .setup_valid_o(setup_valid),
    .setup_pkt_o(setup_pkt), .bulk_valid_o(bulk_valid), .bulk_ep_o(bulk_ep), .bulk_data_o(bulk_data));
  initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end
  // The far side acks one cycle after it sees a request, a single-cycle pulse.
  always @(posedge clock_i) dsp_ack <= (dsp_req === 1'b1) && !dsp_ack;
  always @(posedge clock_i) begin
    if (pm_we === 1'b1) begin
      pa.push_back(pm_addr);
      pd.push_back(pm_data);
    end
  end
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock_i);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock_i);
    penable <= 1'b1;
    do @(posedge clock_i); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0000_0000);
    chk(nm, rd, exp);
  endtask : rdchk
  task automatic wait_req(input logic lvl);
    for (int k = 0; k < 50 && dsp_req !== lvl; k++) @(posedge clock_i);
  endtask : wait_req
  task automatic do_setup(input logic [7:0] rt, input logic [7:0] rq, input logic [15:0] val,
    input logic [15:0] idx, input logic [15:0] len, input logic [2:0] kd);
    i_host.send_setup(rt, rq, val, idx, len);
    @(posedge clock_i);
    chk("setup_kind", 32'(kind), 32'(kd));
    chk("setup_addr", 32'(saddr), 32'(val));
    chk("setup_len", 32'(slen), 32'(len));
    chk("reg_space", 32'(mcu), 32'(val[15]));
  endtask : do_setup
  task automatic t_bridge;
    wr_io(32'h0000_c155, 16'h1234, 1'b1);
    chk("io_addr", rd, 32'h0000_4155);
    dsp_rdata <= 16'h5a3c;
    wr_io(32'h0000_80aa, 16'h0000, 1'b0);
    rdchk(usb_dl_pkg::OFF_IO_DATA, 32'h0000_5a3c, "io_data");
    rdchk(usb_dl_pkg::OFF_STATUS, 32'h0000_0000, "busy");
  endtask : t_bridge
  task automatic wr_io(input logic [31:0] a, input logic [15:0] d, input logic w);
    if (w) apb(1'b1, usb_dl_pkg::OFF_IO_DATA, 32'(d));
    apb(1'b1, usb_dl_pkg::OFF_IO_ADDR, a);
    wait_req(1'b1);
    chk("dsp_we", 32'(dsp_we), 32'(w));
    chk("dsp_addr", 32'(dsp_addr), 32'(a[13:0]));
    if (w) chk("dsp_wdata", 32'(dsp_wdata), 32'(d));
    wait_req(1'b0);
    apb(1'b0, usb_dl_pkg::OFF_IO_ADDR, 32'h0000_0000);
  endtask : wr_io
  task automatic t_download;
    logic [17:0] base;
    chk("ready_off", 32'(bulk_ready), 32'h0000_0000);
    apb(1'b1, usb_dl_pkg::OFF_CTRL, 32'h0000_0001);
    repeat (2) @(posedge clock_i);
    chk("ready_on", 32'(bulk_ready), 32'h0000_0001);
    for (int e = 1; e <= 3; e++) begin
      base = 18'(e * 'h1_1000);
      apb(1'b1, usb_dl_pkg::OFF_DL_BASE + 12'(4 * (e - 1)), 32'(base));
      rdchk(usb_dl_pkg::OFF_DL_WPTR + 12'(4 * (e - 1)), 32'h0003_ffff, "wptr_load");
      for (int i = 0; i < 2 * e; i++) i_host.send_instr(2'(e), {8'(e), 16'(i) ^ 16'ha5c3});
      repeat (3) @(posedge clock_i);
      chk("pm_count", 32'(pa.size()), 32'(2 * e));
      for (int i = 0; i < 2 * e; i++) begin
        chk("pm_addr", 32'(pa[i]), 32'(base + 18'(i)));
        chk("pm_data", 32'(pd[i]), 32'({8'(e), 16'(i) ^ 16'ha5c3}));
      end
      pa.delete();
      pd.delete();
      rdchk(usb_dl_pkg::OFF_DL_WPTR + 12'(4 * (e - 1)), 32'(2 * e - 1), "wptr_step");
    end
  endtask : t_download
  task automatic ep_chk(input logic [3:0] ep, input logic [1:0] ty, input logic dir, input logic [9:0] mx,
    input logic [17:0] bs, input logic [15:0] sz);
    @(posedge clock_i);
    ep_sel <= ep;
    repeat (2) @(posedge clock_i);
    chk("ep_type", 32'(ep_type), 32'(ty));
    chk("ep_maxpkt", 32'(ep_max), 32'(mx));
    if (ep != 4'h0) chk("ep_dir", 32'(ep_dir), 32'(dir));
    if (ep != 4'h0) chk("ep_base", 32'(ep_base), 32'(bs));
    if (ep > 4'h3) chk("ep_size", 32'(ep_size), 32'(sz));
  endtask : ep_chk
  task automatic t_lookup;
    for (int n = 0; n < 8; n += 7) begin
      apb(1'b1, usb_dl_pkg::OFF_EP_DESC + 12'(4 * n), 32'h0000_0107 + 32'(n));
      apb(1'b1, usb_dl_pkg::OFF_BUF_BASE + 12'(4 * n), 32'h0002_0000 + 32'(n));
      apb(1'b1, usb_dl_pkg::OFF_BUF_SIZE + 12'(4 * n), 32'h0000_0400 + 32'(n));
      apb(1'b1, usb_dl_pkg::OFF_BUF_RD + 12'(4 * n), 32'h0000_0010 + 32'(n));
      rdchk(usb_dl_pkg::OFF_BUF_RD + 12'(4 * n), 32'h0000_0010 + 32'(n), "buf_rd");
      apb(1'b1, usb_dl_pkg::OFF_BUF_WR + 12'(4 * n), 32'h0000_0020 + 32'(n));
      rdchk(usb_dl_pkg::OFF_BUF_WR + 12'(4 * n), 32'h0000_0020 + 32'(n), "buf_wr");
      ep_chk(4'(4 + n), 2'(3 + n), 1'b1, 10'h010, 18'h2_0000 + 18'(n), 16'h0400 + 16'(n));
    end
    ep_chk(4'h0, usb_dl_pkg::XFER_CONTROL, 1'b0, usb_dl_pkg::CTRL_EP_MAXPKT, 18'h0_0000, 16'h0000);
    ep_chk(4'h2, usb_dl_pkg::XFER_BULK, 1'b0, usb_dl_pkg::CODE_EP_MAXPKT, 18'h2_2000, 16'h0000);
    apb(1'b0, 12'h0f0, 32'h0000_0000);
    chk("unmapped_err", 32'(er), 32'h0000_0001);
    chk("unmapped_data", rd, 32'h0000_0000);
  endtask : t_lookup
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : print_verdict
  initial begin
    repeat (20000) @(posedge clock_i);
    n_mismatch++;
    print_verdict();
  end
  initial begin
    {rst_i, psel, penable, pwrite, paddr, pwdata, dsp_rdata, ep_sel} = {1'b1, 67'h0};
    repeat (10) @(posedge clock_i);
    chk("rst_maxpkt", 32'(ep_max), 32'h0000_0008);
    rst_i <= 1'b0;
    do_setup(8'h40, 8'ha1, 16'h1234, 16'h0000, 16'h0100, usb_dl_pkg::KIND_MCU_CODE);
    do_setup(8'h40, 8'ha0, 16'h8010, 16'h0000, 16'h0002, usb_dl_pkg::KIND_REG_WRITE);
    do_setup(8'hc0, 8'ha0, 16'h0010, 16'h0000, 16'h0002, usb_dl_pkg::KIND_REG_READ);
    do_setup(8'h40, 8'ha0, 16'h0010, 16'h0000, 16'h0003, usb_dl_pkg::KIND_OTHER);
    do_setup(8'h40, 8'ha1, 16'h0010, 16'h0001, 16'h0004, usb_dl_pkg::KIND_OTHER);
    t_bridge();
    t_download();
    t_lookup();
    print_verdict();
  end
endmodule : usb_code_download_bridge_tb
